// ==== verilog/bsfe_pkg.sv ====
package bsfe_pkg;

   // status register bit positions
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_V = 3;
   localparam int SR_S = 4;
   localparam int SR_H = 5;
   localparam int SR_T = 6;
   localparam int SR_I = 7;

   // cycle counts and program counter advances
   localparam logic [1:0] CYC_FALL = 2'h1;
   localparam logic [1:0] CYC_TAKEN = 2'h2;
   localparam int SKIP_ONE_WORD = 2;
   localparam int SKIP_TWO_WORD = 3;
   localparam int BRANCH_BIAS = 1;

   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TAKEN_CNT = 8'h08;
   localparam logic [7:0] OFS_FALL_CNT = 8'h0C;

   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TAKEN_BIT = 1;
   localparam int STAT_CYC_LSB = 4;

   // reset values
   localparam logic CTRL_ENABLE_RST = 1'b1;

   typedef enum logic [4:0] {
      OP_NONE,
      OP_SKIP_IF_REG_BIT_SET,
      OP_SKIP_IF_IO_BIT_CLEAR,
      OP_SKIP_IF_IO_BIT_SET,
      OP_BRANCH_FLAG_BIT_SET,
      OP_BRANCH_FLAG_BIT_CLEAR,
      OP_BRANCH_EQUAL,
      OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_OR_HIGHER,
      OP_BRANCH_LOWER,
      OP_BRANCH_MINUS,
      OP_BRANCH_PLUS,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR,
      OP_BRANCH_TRANSFER_FLAG_SET,
      OP_BRANCH_TRANSFER_FLAG_CLEAR,
      OP_BRANCH_OVERFLOW_SET,
      OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_IRQ_ENABLED,
      OP_BRANCH_IRQ_DISABLED
   } bsfe_op_e;

   typedef enum {
      ST_IDLE,
      ST_EXTRA
   } bsfe_state_e;

endpackage : bsfe_pkg

// ==== verilog/bsfe_cond_if.sv ====
`timescale 1ns/1ps
interface bsfe_cond_if
   import bsfe_pkg::*;
();
   bsfe_op_e   op;
   logic [2:0] bit_sel;
   logic [7:0] reg_val;
   logic [7:0] io_val;
   logic [7:0] status_register;
   logic       hit;
   logic       is_skip;
   logic       is_branch;

   modport req  (output op, bit_sel, reg_val, io_val, status_register,
                 input  hit, is_skip, is_branch);
   modport eval (input  op, bit_sel, reg_val, io_val, status_register,
                 output hit, is_skip, is_branch);
endinterface : bsfe_cond_if

// ==== verilog/bsfe_cond.sv ====
`timescale 1ns/1ps
module bsfe_cond
   import bsfe_pkg::*;
(
   bsfe_cond_if.eval cif
);

   logic [7:0] sr;

   assign sr = cif.status_register;

   always_comb begin
      cif.hit = 1'b0;
      cif.is_skip = 1'b0;
      cif.is_branch = 1'b1;
      case (cif.op)
         OP_SKIP_IF_REG_BIT_SET: begin
            cif.is_skip = 1'b1;
            cif.is_branch = 1'b0;
            cif.hit = cif.reg_val[cif.bit_sel];
         end
         OP_SKIP_IF_IO_BIT_CLEAR: begin
            cif.is_skip = 1'b1;
            cif.is_branch = 1'b0;
            cif.hit = ~cif.io_val[cif.bit_sel];
         end
         OP_SKIP_IF_IO_BIT_SET: begin
            cif.is_skip = 1'b1;
            cif.is_branch = 1'b0;
            cif.hit = cif.io_val[cif.bit_sel];
         end
         OP_BRANCH_FLAG_BIT_SET:        cif.hit = sr[cif.bit_sel];
         OP_BRANCH_FLAG_BIT_CLEAR:      cif.hit = ~sr[cif.bit_sel];
         OP_BRANCH_EQUAL:               cif.hit = sr[SR_Z];
         OP_BRANCH_NOT_EQUAL:           cif.hit = ~sr[SR_Z];
         OP_BRANCH_CARRY_SET,
         OP_BRANCH_LOWER:               cif.hit = sr[SR_C];
         OP_BRANCH_CARRY_CLEAR,
         OP_BRANCH_SAME_OR_HIGHER:      cif.hit = ~sr[SR_C];
         OP_BRANCH_MINUS:               cif.hit = sr[SR_N];
         OP_BRANCH_PLUS:                cif.hit = ~sr[SR_N];
         OP_BRANCH_SIGNED_GE:           cif.hit = ~(sr[SR_N] ^ sr[SR_V]);
         OP_BRANCH_SIGNED_LT:           cif.hit = sr[SR_N] ^ sr[SR_V];
         OP_BRANCH_HALFCARRY_SET:       cif.hit = sr[SR_H];
         OP_BRANCH_HALFCARRY_CLEAR:     cif.hit = ~sr[SR_H];
         OP_BRANCH_TRANSFER_FLAG_SET:   cif.hit = sr[SR_T];
         OP_BRANCH_TRANSFER_FLAG_CLEAR: cif.hit = ~sr[SR_T];
         OP_BRANCH_OVERFLOW_SET:        cif.hit = sr[SR_V];
         OP_BRANCH_OVERFLOW_CLEAR:      cif.hit = ~sr[SR_V];
         OP_BRANCH_IRQ_ENABLED:         cif.hit = sr[SR_I];
         OP_BRANCH_IRQ_DISABLED:        cif.hit = ~sr[SR_I];
         default: begin
            cif.is_branch = 1'b0;
            cif.hit = 1'b0;
         end
      endcase
   end

endmodule : bsfe_cond

// ==== verilog/bsfe_exec.sv ====
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module bsfe_exec
   import bsfe_pkg::*;
#(
   parameter int PC_W  = 9,
   parameter int OFS_W = 7,
   parameter int CNT_W = 16
) (
   input  wire logic             sys_clk_i,
   input  wire logic             nrst_i,
   // instruction side
   input  wire logic             instr_valid_i,
   input  wire bsfe_op_e         instr_op_i,
   input  wire logic [2:0]       bit_sel_i,
   input  wire logic [OFS_W-1:0] offset_i,
   input  wire logic [PC_W-1:0]  pc_i,
   input  wire logic             next_two_word_i,
   input  wire logic [7:0]       reg_val_i,
   input  wire logic [7:0]       io_val_i,
   input  wire logic [7:0]       status_register_i,
   output logic                  ready_o,
   output logic                  done_o,
   output logic                  taken_o,
   output logic                  pc_load_o,
   output logic [PC_W-1:0]       pc_next_o,
   output logic                  squash_o,
   output logic [1:0]            cycles_o,
   // apb slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [7:0]       paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic [31:0]           prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o
);

   ////////////////////////////////////////////////////////////////////////
   // condition evaluation

   bsfe_cond_if cif ();

   assign cif.op = instr_op_i;
   assign cif.bit_sel = bit_sel_i;
   assign cif.reg_val = reg_val_i;
   assign cif.io_val = io_val_i;
   assign cif.status_register = status_register_i;

   bsfe_cond u_cond (
      .cif (cif)
   );

   ////////////////////////////////////////////////////////////////////////
   // control registers

   logic             exec_enable;
   logic             cnt_clear;
   logic [CNT_W-1:0] taken_cnt;
   logic [CNT_W-1:0] fall_cnt;
   logic             apb_wr;
   logic             apb_setup;

   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign apb_setup = psel_i & ~penable_i;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         exec_enable <= CTRL_ENABLE_RST;
      end else if (apb_wr && paddr_i == OFS_CTRL) begin
         exec_enable <= pwdata_i[CTRL_ENABLE_BIT];
      end
   end

   // counter clear is a one-cycle strobe
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_clear <= 1'b0;
      end else begin
         cnt_clear <= apb_wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_CLEAR_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing

   bsfe_state_e      state;
   bsfe_state_e      next_state;
   logic             accept;
   logic             redirect;
   logic [PC_W-1:0]  ofs_ext;
   logic [PC_W-1:0]  branch_target;
   logic [PC_W-1:0]  skip_target;
   logic [PC_W-1:0]  fall_target;
   logic [PC_W-1:0]  next_pc;

   assign ready_o = (state == ST_IDLE) & exec_enable;
   assign accept = instr_valid_i & ready_o & (cif.is_skip | cif.is_branch);
   assign redirect = accept & cif.hit;

   assign ofs_ext = PC_W'($signed(offset_i));
   assign branch_target = pc_i + ofs_ext + PC_W'(BRANCH_BIAS);
   assign skip_target = next_two_word_i ? pc_i + PC_W'(SKIP_TWO_WORD)
                                        : pc_i + PC_W'(SKIP_ONE_WORD);
   assign fall_target = pc_i + PC_W'(1);

   always_comb begin
      next_pc = fall_target;
      if (cif.hit && cif.is_skip) begin
         next_pc = skip_target;
      end else if (cif.hit && cif.is_branch) begin
         next_pc = branch_target;
      end
   end

   // a taken skip or taken branch holds the issue slot one more cycle
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (redirect) begin
               next_state = ST_EXTRA;
            end
         end
         ST_EXTRA: next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result outputs

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done_o <= 1'b0;
         taken_o <= 1'b0;
         pc_load_o <= 1'b0;
         squash_o <= 1'b0;
         cycles_o <= CYC_FALL;
         pc_next_o <= '0;
      end else begin
         done_o <= accept;
         pc_load_o <= redirect;
         // the fetched successor is killed before it writes anything
         squash_o <= redirect;
         if (accept) begin
            taken_o <= cif.hit;
            cycles_o <= cif.hit ? CYC_TAKEN : CYC_FALL;
            pc_next_o <= next_pc;
         end
      end
   end

   // no flag output exists: the status register is only read here

   ////////////////////////////////////////////////////////////////////////
   // statistics

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         taken_cnt <= '0;
      end else if (cnt_clear) begin
         taken_cnt <= redirect ? CNT_W'(1) : '0;
      end else if (redirect) begin
         taken_cnt <= taken_cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fall_cnt <= '0;
      end else if (cnt_clear) begin
         fall_cnt <= (accept && !cif.hit) ? CNT_W'(1) : '0;
      end else if (accept && !cif.hit) begin
         fall_cnt <= fall_cnt + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read path

   logic [31:0] rd_mux;
   logic        rd_err;

   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      case (paddr_i)
         OFS_CTRL: rd_mux[CTRL_ENABLE_BIT] = exec_enable;
         OFS_STATUS: begin
            rd_mux[STAT_BUSY_BIT] = (state != ST_IDLE);
            rd_mux[STAT_TAKEN_BIT] = taken_o;
            rd_mux[STAT_CYC_LSB +: 2] = cycles_o;
         end
         OFS_TAKEN_CNT: rd_mux[CNT_W-1:0] = taken_cnt;
         OFS_FALL_CNT:  rd_mux[CNT_W-1:0] = fall_cnt;
         default:       rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_o <= '0;
         pslverr_o <= 1'b0;
      end else if (apb_setup) begin
         prdata_o <= pwrite_i ? '0 : rd_mux;
         pslverr_o <= rd_err;
      end
   end

   assign pready_o = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_reg_skip_adv: assert property (
      accept && instr_op_i == OP_SKIP_IF_REG_BIT_SET && reg_val_i[bit_sel_i]
      |=> pc_load_o && cycles_o == CYC_TAKEN
          && pc_next_o == PC_W'($past(pc_i) + ($past(next_two_word_i) ? SKIP_TWO_WORD
                                                                       : SKIP_ONE_WORD)))
      else $error("register bit skip wrong advance");

   a_io_clr_skip: assert property (
      accept && instr_op_i == OP_SKIP_IF_IO_BIT_CLEAR
      |=> taken_o == !$past(io_val_i[bit_sel_i]))
      else $error("io bit clear skip wrong decision");

   a_io_skip_adv: assert property (
      accept && instr_op_i == OP_SKIP_IF_IO_BIT_CLEAR && !io_val_i[bit_sel_i]
      |=> squash_o && cycles_o == CYC_TAKEN
          && pc_next_o == PC_W'($past(pc_i) + ($past(next_two_word_i) ? SKIP_TWO_WORD
                                                                       : SKIP_ONE_WORD)))
      else $error("io bit clear skip wrong advance");

   a_io_set_skip: assert property (
      accept && instr_op_i == OP_SKIP_IF_IO_BIT_SET
      |=> taken_o == $past(io_val_i[bit_sel_i]))
      else $error("io bit set skip wrong decision");

   a_flag_bit_br: assert property (
      accept && instr_op_i == OP_BRANCH_FLAG_BIT_CLEAR
      |=> taken_o == !$past(status_register_i[bit_sel_i]))
      else $error("flag bit branch wrong decision");

   a_flag_set_br: assert property (
      accept && instr_op_i == OP_BRANCH_FLAG_BIT_SET
      |=> taken_o == $past(status_register_i[bit_sel_i]))
      else $error("flag bit set branch wrong decision");

   a_branch_target: assert property (
      redirect && cif.is_branch
      |=> pc_load_o && pc_next_o == $past(branch_target) && !ready_o
          ##1 (state == ST_IDLE))
      else $error("taken branch wrong target or timing");

   a_fall_one: assert property (
      accept && !cif.hit |=> !pc_load_o && cycles_o == CYC_FALL && ready_o)
      else $error("fall through not single cycle");

   a_eq_zero: assert property (
      accept && instr_op_i == OP_BRANCH_NOT_EQUAL
      |=> taken_o == !$past(status_register_i[SR_Z]))
      else $error("not equal branch wrong decision");

   a_eq_set: assert property (
      accept && instr_op_i == OP_BRANCH_EQUAL
      |=> taken_o == $past(status_register_i[SR_Z]))
      else $error("equal branch wrong decision");

   a_carry_br: assert property (
      accept && instr_op_i == OP_BRANCH_SAME_OR_HIGHER
      |=> taken_o == !$past(status_register_i[SR_C]))
      else $error("same or higher branch wrong decision");

   a_minus_br: assert property (
      accept && instr_op_i == OP_BRANCH_MINUS
      |=> taken_o == $past(status_register_i[SR_N]))
      else $error("minus branch wrong decision");

   a_signed_br: assert property (
      accept && instr_op_i == OP_BRANCH_SIGNED_LT
      |=> taken_o == ($past(status_register_i[SR_N]) ^ $past(status_register_i[SR_V])))
      else $error("signed less branch wrong decision");

   a_half_br: assert property (
      accept && instr_op_i == OP_BRANCH_HALFCARRY_SET
      |=> taken_o == $past(status_register_i[SR_H]))
      else $error("half carry branch wrong decision");

   a_transfer_br: assert property (
      accept && instr_op_i == OP_BRANCH_TRANSFER_FLAG_CLEAR
      |=> taken_o == !$past(status_register_i[SR_T]))
      else $error("transfer flag branch wrong decision");

   a_ovf_br: assert property (
      accept && instr_op_i == OP_BRANCH_OVERFLOW_SET
      |=> taken_o == $past(status_register_i[SR_V]))
      else $error("overflow branch wrong decision");

   a_irq_br: assert property (
      accept && instr_op_i == OP_BRANCH_IRQ_DISABLED
      |=> taken_o == !$past(status_register_i[SR_I]))
      else $error("irq branch wrong decision");

   a_squash_pair: assert property (
      done_o |-> squash_o == taken_o && pc_load_o == taken_o)
      else $error("squash not tied to redirect");

   a_squash_once: assert property (
      squash_o |-> !ready_o ##1 !squash_o)
      else $error("squash not a single cycle");

   c_skip_taken: cover property (accept && cif.is_skip && cif.hit);
   c_branch_taken: cover property (redirect && cif.is_branch ##2 accept);
   c_fall_b2b: cover property (accept && !cif.hit ##1 accept);
   c_apb_err: cover property (psel_i && penable_i && pslverr_o);
   c_skip_two: cover property (accept && cif.is_skip && cif.hit && next_two_word_i);

endmodule : bsfe_exec

// ==== test/tb_branch_skip_flow_exec.sv ====
`timescale 1ns/1ps
module tb_branch_skip_flow_exec import bsfe_pkg::*;;
   logic        sys_clk_i;
   logic        nrst_i;
   logic        instr_valid_i;
   bsfe_op_e    instr_op_i;
   logic [2:0]  bit_sel_i;
   logic [6:0]  offset_i;
   logic [8:0]  pc_i;
   logic        next_two_word_i;
   logic [7:0]  status_register_i;
   logic        ready_o, done_o, taken_o, pc_load_o, squash_o;
   logic [8:0]  pc_next_o;
   logic [1:0]  cycles_o;
   logic        psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o;
   int          err_total, checks_done, cnt_taken, cnt_fall;

   bsfe_exec dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
      .instr_op_i(instr_op_i), .bit_sel_i(bit_sel_i), .offset_i(offset_i), .pc_i(pc_i),
      .next_two_word_i(next_two_word_i), .reg_val_i(status_register_i),
      .io_val_i(status_register_i), .status_register_i(status_register_i),
      .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o), .pc_load_o(pc_load_o),
      .pc_next_o(pc_next_o), .squash_o(squash_o), .cycles_o(cycles_o), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

   always #50 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic timeout_hit();
      err_total++;
      complete_run();
   endtask : timeout_hit

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // same value drives register, io and status inputs
   function automatic logic exp_take(bsfe_op_e op, logic [2:0] b, logic [7:0] v);
      case (op)
         OP_SKIP_IF_REG_BIT_SET:        return v[b];
         OP_SKIP_IF_IO_BIT_CLEAR:       return !v[b];
         OP_SKIP_IF_IO_BIT_SET:         return v[b];
         OP_BRANCH_FLAG_BIT_SET:        return v[b];
         OP_BRANCH_FLAG_BIT_CLEAR:      return !v[b];
         OP_BRANCH_EQUAL:               return v[SR_Z];
         OP_BRANCH_NOT_EQUAL:           return !v[SR_Z];
         OP_BRANCH_CARRY_SET:           return v[SR_C];
         OP_BRANCH_LOWER:               return v[SR_C];
         OP_BRANCH_CARRY_CLEAR:         return !v[SR_C];
         OP_BRANCH_SAME_OR_HIGHER:      return !v[SR_C];
         OP_BRANCH_MINUS:               return v[SR_N];
         OP_BRANCH_PLUS:                return !v[SR_N];
         OP_BRANCH_SIGNED_GE:           return !(v[SR_N] ^ v[SR_V]);
         OP_BRANCH_SIGNED_LT:           return v[SR_N] ^ v[SR_V];
         OP_BRANCH_HALFCARRY_SET:       return v[SR_H];
         OP_BRANCH_HALFCARRY_CLEAR:     return !v[SR_H];
         OP_BRANCH_TRANSFER_FLAG_SET:   return v[SR_T];
         OP_BRANCH_TRANSFER_FLAG_CLEAR: return !v[SR_T];
         OP_BRANCH_OVERFLOW_SET:        return v[SR_V];
         OP_BRANCH_OVERFLOW_CLEAR:      return !v[SR_V];
         OP_BRANCH_IRQ_ENABLED:         return v[SR_I];
         OP_BRANCH_IRQ_DISABLED:        return !v[SR_I];
         default:                       return 1'h0;
      endcase
   endfunction : exp_take

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                           output logic [31:0] rd, output logic err);
      int n;
      @(posedge sys_clk_i);
      psel_i    <= 1'h1;
      penable_i <= 1'h0;
      pwrite_i  <= wr;
      paddr_i   <= addr;
      pwdata_i  <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'h1 && n < 20);
      if (pready_o !== 1'h1) timeout_hit();
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb_xfer

   task automatic apb_check(input logic [7:0] addr, input logic [31:0] exp, input logic e_err,
                            input string what);
      logic [31:0] rd;
      logic        err;
      apb_xfer(1'h0, addr, 32'h0000_0000, rd, err);
      check(what, rd, exp);
      check("pslverr", 32'(err), 32'(e_err));
   endtask : apb_check

   task automatic run_op(input bsfe_op_e op, input logic [2:0] b, input logic [6:0] k,
                         input logic [8:0] pc, input logic two, input logic [7:0] sr);
      logic       tk;
      logic [8:0] exp_pc;
      int         n;
      tk = exp_take(op, b, sr);
      if (!tk) exp_pc = pc + 9'h001;
      else if (op inside {OP_SKIP_IF_REG_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR,
                          OP_SKIP_IF_IO_BIT_SET})
         exp_pc = pc + (two ? 9'(SKIP_TWO_WORD) : 9'(SKIP_ONE_WORD));
      else exp_pc = pc + {{2{k[6]}}, k} + 9'(BRANCH_BIAS);
      for (n = 0; n < 20 && ready_o !== 1'h1; n++) @(posedge sys_clk_i);
      if (n == 20) timeout_hit();
      @(posedge sys_clk_i);
      instr_valid_i     <= 1'h1;
      instr_op_i        <= op;
      bit_sel_i         <= b;
      offset_i          <= k;
      pc_i              <= pc;
      next_two_word_i   <= two;
      status_register_i <= sr;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'h0;
      #1;
      check("done", 32'(done_o), 32'h0000_0001);
      check("pc_load", 32'(pc_load_o), 32'(tk));
      check("taken", 32'(taken_o), 32'(tk));
      check("squash", 32'(squash_o), 32'(tk));
      check("cycles", 32'(cycles_o), 32'(tk ? CYC_TAKEN : CYC_FALL));
      check("pc_next", 32'(pc_next_o), 32'(exp_pc));
      check("ready_mid", 32'(ready_o), 32'(!tk));
      @(posedge sys_clk_i);
      #1;
      check("done_end", 32'(done_o), 32'h0000_0000);
      check("ready_end", 32'(ready_o), 32'h0000_0001);
      if (tk) cnt_taken++;
      else cnt_fall++;
   endtask : run_op

   // two fall-through branches offered on consecutive edges
   task automatic back_to_back();
      @(posedge sys_clk_i);
      instr_valid_i     <= 1'h1;
      instr_op_i        <= OP_BRANCH_EQUAL;
      status_register_i <= 8'h00;
      pc_i              <= 9'h010;
      @(posedge sys_clk_i);
      instr_op_i        <= OP_BRANCH_NOT_EQUAL;
      status_register_i <= 8'hFF;
      pc_i              <= 9'h011;
      #1;
      check("b2b_pc1", 32'(pc_next_o), 32'h0000_0011);
      @(posedge sys_clk_i);
      instr_valid_i <= 1'h0;
      #1;
      check("b2b_done", 32'(done_o), 32'h0000_0001);
      check("b2b_pc2", 32'(pc_next_o), 32'h0000_0012);
      check("b2b_taken", 32'(taken_o), 32'h0000_0000);
      cnt_fall += 2;
   endtask : back_to_back

   task automatic refused(input bsfe_op_e op, input logic exp_ready);
      @(posedge sys_clk_i);
      instr_valid_i     <= 1'h1;
      instr_op_i        <= op;
      status_register_i <= 8'hFF;
      repeat (3) begin
         @(posedge sys_clk_i);
         #1;
         check("refused_done", 32'(done_o), 32'h0000_0000);
         check("refused_ready", 32'(ready_o), 32'(exp_ready));
      end
      @(posedge sys_clk_i);
      instr_valid_i <= 1'h0;
   endtask : refused

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] rd;
      logic        err;
      logic [7:0]  pat [3];
      pat = '{8'hA5, 8'h5A, 8'h00};
      sys_clk_i = 1'h0;
      nrst_i = 1'h0;
      instr_valid_i = 1'h0;
      instr_op_i = OP_NONE;
      bit_sel_i = 3'h0;
      offset_i = 7'h00;
      pc_i = 9'h000;
      next_two_word_i = 1'h0;
      status_register_i = 8'h00;
      psel_i = 1'h0;
      penable_i = 1'h0;
      pwrite_i = 1'h0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0000_0000;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'h1;
      #1;
      check("rst_ready", 32'(ready_o), 32'h0000_0001);
      check("rst_cycles", 32'(cycles_o), 32'h0000_0001);
      check("rst_pc_next", 32'(pc_next_o), 32'h0000_0000);
      apb_check(OFS_CTRL, 32'h0000_0001, 1'h0, "ctrl_rst");
      apb_check(OFS_STATUS, 32'h0000_0010, 1'h0, "status_rst");
      apb_check(OFS_TAKEN_CNT, 32'h0000_0000, 1'h0, "taken_cnt_rst");
      apb_check(OFS_FALL_CNT, 32'h0000_0000, 1'h0, "fall_cnt_rst");
      apb_check(8'h10, 32'h0000_0000, 1'h1, "unmapped");
      for (int p = 0; p < 3; p++) begin
         for (int i = 1; i <= 23; i++) begin
            run_op(bsfe_op_e'(i), 3'(i + p), (p == 1) ? 7'h40 : 7'h05 + 7'(p * 58),
                   (p == 0) ? 9'h1FE : 9'(p * 128 - 125), p[0], pat[p]);
         end
      end
      // last op taken: cycles 2 in bits 5:4, taken in bit 1
      apb_check(OFS_STATUS, 32'h0000_0022, 1'h0, "status_last");
      back_to_back();
      apb_check(OFS_TAKEN_CNT, 32'(cnt_taken), 1'h0, "taken_cnt");
      apb_check(OFS_FALL_CNT, 32'(cnt_fall), 1'h0, "fall_cnt");
      refused(OP_NONE, 1'h1);
      apb_xfer(1'h1, OFS_CTRL, 32'h0000_0000, rd, err);
      refused(OP_BRANCH_IRQ_ENABLED, 1'h0);
      apb_xfer(1'h1, 8'h10, 32'h0000_0000, rd, err);
      apb_xfer(1'h1, OFS_CTRL, 32'h0000_0003, rd, err);
      apb_check(OFS_TAKEN_CNT, 32'h0000_0000, 1'h0, "taken_cnt_clr");
      apb_check(OFS_FALL_CNT, 32'h0000_0000, 1'h0, "fall_cnt_clr");
      run_op(OP_BRANCH_SIGNED_LT, 3'h0, 7'h7F, 9'h000, 1'h0, 8'h04);
      complete_run();
   end
endmodule : tb_branch_skip_flow_exec
